// ===== design/pfvs_consts.vh
// Constants for the page FIFO and video serializer block
`ifndef PFVS_CONSTS_VH
`define PFVS_CONSTS_VH
`define PFVS_BLOCK_MAX        10'h200
`define PFVS_LINE_BYTES       9'h12c
`define PFVS_FIFO_DEPTH       32
`define PFVS_FIFO_AW          5
`define PFVS_CLK_HZ           10000000
`define PFVS_PEAK_BPS         558000
`define PFVS_BYTE_CYC         (`PFVS_CLK_HZ / `PFVS_PEAK_BPS)
`define PFVS_SHIFT_DIV        4'h2
`define PFVS_ROP_OR           2'h0
`define PFVS_ROP_XOR          2'h1
`define PFVS_ROP_COPY         2'h2
`define PFVS_ROP_CLEAR        2'h3
`define PFVS_SRC_HOST         1'b0
`define PFVS_SRC_LINE         1'b1
`endif

// ===== design/pfvs_fifo.v
// Synchronous FIFO with valid/ready on both sides
`include "pfvs_consts.vh"
`default_nettype none
module pfvs_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = `PFVS_FIFO_DEPTH,
  parameter AW    = `PFVS_FIFO_AW
) (
  // Clock and reset
  input  wire             i_clk,
  input  wire             i_rst,
  // Fill side
  input  wire             i_in_valid,
  output wire             o_in_ready,
  input  wire [WIDTH-1:0] i_in_data,
  // Drain side
  output wire             o_out_valid,
  input  wire             i_out_ready,
  output wire [WIDTH-1:0] o_out_data,
  // Status
  output wire [AW:0]      o_level
);
  reg  [WIDTH-1:0] mem [0:DEPTH-1];
  reg  [AW-1:0]    wr_ptr;
  reg  [AW-1:0]    rd_ptr;
  reg  [AW:0]      count;
  wire             push;
  wire             pop;

  ////////////////////////////////////////////////////////////////////////////
  // Handshake terms; full and empty come straight from the count
  assign o_in_ready  = (count != DEPTH[AW:0]);
  assign o_out_valid = (count != {(AW+1){1'b0}});
  assign push        = i_in_valid & o_in_ready;
  assign pop         = o_out_valid & i_out_ready;
  assign o_out_data  = mem[rd_ptr];
  assign o_level     = count;

  // Pointers and occupancy
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count  <= {(AW+1){1'b0}};
    end else begin
      if (push)
        wr_ptr <= wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= rd_ptr + 1'b1;
      if (push & ~pop)
        count <= count + 1'b1;
      else if (pop & ~push)
        count <= count - 1'b1;
    end
  end

  // Storage has no reset; only written entries are ever read
  always @(posedge i_clk) begin
    if (push)
      mem[wr_ptr] <= i_in_data;
  end
endmodule // pfvs_fifo
`default_nettype wire

// ===== design/pfvs_top.v
// Page FIFO, frame-buffer raster write path and video serializer
// Operation
// - Host blocks are at most 512 bytes
// - Mover writes host bytes into FIFO directly
// - Mover accepts a loaded byte count first
// - Mover moves exactly count bytes, then stops
// - Mover sustains up to 558 KB per second
// - Drain FIFO into frame buffer at address
// - Frame write applies OR, XOR, copy, clear
// - Print request only after whole page built
// - First scan line bytes fill the FIFO before output
// - Scan line is about 300 bytes
// - Serialize only after engine signals ready
// - Refill FIFO with next line after last
// - Output is serial dot bit stream
// - Video logic generates the shift clock
`include "pfvs_consts.vh"
`default_nettype none
module pfvs_top #(
  parameter AW         = 20,
  parameter DEPTH      = `PFVS_FIFO_DEPTH,
  parameter FAW        = `PFVS_FIFO_AW,
  parameter LINE_BYTES = `PFVS_LINE_BYTES
) (
  // Clock and reset
  input  wire          i_clk,
  input  wire          i_rst,
  // Processor side: counted mover setup
  input  wire          i_cnt_load,
  input  wire [9:0]    i_cnt_value,
  output reg           o_mover_busy,
  output reg           o_cnt_error,
  // Bus controller byte port (same clock domain)
  input  wire          i_host_valid,
  output wire          o_host_ready,
  input  wire [7:0]    i_host_data,
  // Processor side: raster command
  input  wire          i_rop_start,
  input  wire [AW-1:0] i_rop_addr,
  input  wire [1:0]    i_rop_op,
  input  wire          i_page_done,
  output reg           o_rop_busy,
  // Frame buffer read-modify-write port
  output reg           o_fb_rd,
  output reg           o_fb_wr,
  output reg  [AW-1:0] o_fb_addr,
  output reg  [7:0]    o_fb_wdata,
  input  wire [7:0]    i_fb_rdata,
  input  wire          i_fb_rvalid,
  // Scan line reload
  input  wire          i_line_valid,
  output wire          o_line_ready,
  input  wire [7:0]    i_line_data,
  output reg           o_line_request,
  output reg  [8:0]    o_line_index,
  // Engine control board link
  input  wire          i_engine_ready,
  output reg           o_print_request,
  output reg           o_video_data,
  output reg           o_shift_clk,
  output reg           o_line_sent
);
  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  localparam M_IDLE = 2'h0;
  localparam M_RUN  = 2'h1;
  localparam M_WAIT = 2'h2;
  localparam R_IDLE = 2'h0;
  localparam R_READ = 2'h1;
  localparam R_WAIT = 2'h2;
  localparam R_WRITE = 2'h3;
  localparam V_IDLE = 2'h0;
  localparam V_LOAD = 2'h1;
  localparam V_SHIFT = 2'h2;
  localparam integer PACE_I = ((`PFVS_BYTE_CYC) > 0) ? (`PFVS_BYTE_CYC) : 1;
  localparam [7:0] PACE = PACE_I[7:0];

  reg  [1:0]  mstate;
  reg  [9:0]  remain;
  reg  [7:0]  pace;
  reg  [1:0]  rstate;
  reg  [1:0]  rop;
  reg  [7:0]  rop_byte;
  reg         page_built;
  reg         printing;
  reg  [1:0]  vstate;
  reg  [7:0]  shreg;
  reg  [2:0]  bitn;
  reg  [3:0]  div;
  reg  [8:0]  vcount;
  reg  [8:0]  load_count;
  reg         rdy_s1;
  reg         rdy_s2;
  reg  [7:0]  next_fb;
  wire        fifo_in_valid;
  wire        fifo_in_ready;
  wire [7:0]  fifo_in_data;
  wire        fifo_out_valid;
  wire        fifo_out_ready;
  wire [7:0]  fifo_out_data;
  wire        mover_take;
  wire        line_take;

  ////////////////////////////////////////////////////////////////////////////
  // Shared FIFO; its source switches from host bytes to scan lines at print
  assign mover_take    = (mstate == M_RUN) & (pace == 8'h00) & i_host_valid & fifo_in_ready;
  assign o_host_ready  = (mstate == M_RUN) & (pace == 8'h00) & fifo_in_ready;
  assign line_take     = printing & (load_count != LINE_BYTES[8:0]) & i_line_valid & fifo_in_ready;
  assign o_line_ready  = printing & (load_count != LINE_BYTES[8:0]) & fifo_in_ready;
  assign fifo_in_valid = printing ? line_take : mover_take;
  assign fifo_in_data  = printing ? i_line_data : i_host_data;
  // A new raster command holds off the drain so no byte is popped and dropped
  assign fifo_out_ready = printing ? (vstate == V_LOAD) : (rstate == R_IDLE && o_rop_busy && !i_rop_start);

  pfvs_fifo #(
    .WIDTH (8),
    .DEPTH (DEPTH),
    .AW    (FAW)
  ) u_fifo (
    .i_clk       (i_clk),
    .i_rst       (i_rst),
    .i_in_valid  (fifo_in_valid),
    .o_in_ready  (fifo_in_ready),
    .i_in_data   (fifo_in_data),
    .o_out_valid (fifo_out_valid),
    .i_out_ready (fifo_out_ready),
    .o_out_data  (fifo_out_data),
    .o_level     ()
  );

  ////////////////////////////////////////////////////////////////////////////
  // Counted mover: load a count, then move that many bytes unattended
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      mstate       <= M_IDLE;
      remain       <= 10'h000;
      pace         <= 8'h00;
      o_mover_busy <= 1'b0;
      o_cnt_error  <= 1'b0;
    end else begin
      if (pace != 8'h00)
        pace <= pace - 8'h01;
      case (mstate)
        M_IDLE: begin
          if (i_cnt_load && !printing) begin
            // Oversized or empty blocks are refused rather than truncated
            if (i_cnt_value == 10'h000 || i_cnt_value > `PFVS_BLOCK_MAX) begin
              o_cnt_error <= 1'b1;
            end else begin
              remain       <= i_cnt_value;
              o_cnt_error  <= 1'b0;
              o_mover_busy <= 1'b1;
              mstate       <= M_RUN;
            end
          end
        end
        M_RUN: begin
          if (mover_take) begin
            pace   <= PACE - 8'h01;
            remain <= remain - 10'h001;
            if (remain == 10'h001) begin
              mstate <= M_WAIT;
            end
          end
        end
        M_WAIT: begin
          o_mover_busy <= 1'b0;
          mstate       <= M_IDLE;
        end
        default: mstate <= M_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Combine operation on the old frame-buffer byte
  always @* begin
    case (rop)
      `PFVS_ROP_OR:    next_fb = i_fb_rdata | rop_byte;
      `PFVS_ROP_XOR:   next_fb = i_fb_rdata ^ rop_byte;
      `PFVS_ROP_COPY:  next_fb = rop_byte;
      `PFVS_ROP_CLEAR: next_fb = i_fb_rdata & ~rop_byte;
      default:         next_fb = rop_byte;
    endcase
  end

  // Raster writer: drains FIFO bytes to consecutive frame addresses
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rstate     <= R_IDLE;
      rop        <= `PFVS_ROP_COPY;
      rop_byte   <= 8'h00;
      o_rop_busy <= 1'b0;
      o_fb_rd    <= 1'b0;
      o_fb_wr    <= 1'b0;
      o_fb_addr  <= {AW{1'b0}};
      o_fb_wdata <= 8'h00;
    end else begin
      o_fb_rd <= 1'b0;
      o_fb_wr <= 1'b0;
      case (rstate)
        R_IDLE: begin
          if (i_rop_start && !printing) begin
            o_rop_busy <= 1'b1;
            rop        <= i_rop_op;
            o_fb_addr  <= i_rop_addr;
          end else if (o_rop_busy && fifo_out_valid) begin
            rop_byte <= fifo_out_data;
            o_fb_rd  <= 1'b1;
            rstate   <= R_WAIT;
          end else if (o_rop_busy && !o_mover_busy && !fifo_out_valid) begin
            o_rop_busy <= 1'b0; // Block drained
          end
        end
        R_WAIT: begin
          // Old byte is only valid with its strobe, so combine and write now
          if (i_fb_rvalid) begin
            o_fb_wr    <= 1'b1;
            o_fb_wdata <= next_fb;
            rstate     <= R_WRITE;
          end
        end
        R_WRITE: begin
          o_fb_addr <= o_fb_addr + 1'b1; // Write is on the port this cycle
          rstate    <= R_IDLE;
        end
        R_READ: begin
          rstate <= R_IDLE;
        end
        default: rstate <= R_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Page state and scan-line reload; print is refused until page is built
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      page_built      <= 1'b0;
      printing        <= 1'b0;
      o_print_request <= 1'b0;
      o_line_request  <= 1'b0;
      o_line_index    <= 9'h000;
      load_count      <= 9'h000;
    end else begin
      o_line_request <= 1'b0;
      if (i_page_done && !o_mover_busy && !o_rop_busy && !printing) begin
        page_built     <= 1'b1;
        printing       <= 1'b1;
        o_line_index   <= 9'h000;
        load_count     <= 9'h000;
        o_line_request <= 1'b1;
      end
      if (line_take)
        load_count <= load_count + 9'h001;
      // Request engine once the whole first line is loaded or the FIFO fills, whichever comes first
      if (printing && page_built && (load_count == LINE_BYTES[8:0] || !fifo_in_ready))
        o_print_request <= 1'b1;
      if (o_line_sent) begin
        load_count     <= 9'h000;
        o_line_index   <= o_line_index + 9'h001;
        o_line_request <= 1'b1;
      end
      if (i_page_done && printing && o_line_sent) begin
        printing        <= 1'b0;
        page_built      <= 1'b0;
        o_print_request <= 1'b0;
        o_line_request  <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Engine ready arrives from the engine board, so it is synchronised
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rdy_s1 <= 1'b0;
      rdy_s2 <= 1'b0;
    end else begin
      rdy_s1 <= i_engine_ready;
      rdy_s2 <= rdy_s1;
    end
  end

  // Video control: FIFO byte to shift register, shifted MSB first
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      vstate       <= V_IDLE;
      shreg        <= 8'h00;
      bitn         <= 3'h0;
      div          <= 4'h0;
      vcount       <= 9'h000;
      o_video_data <= 1'b0;
      o_shift_clk  <= 1'b0;
      o_line_sent  <= 1'b0;
    end else begin
      o_line_sent <= 1'b0;
      case (vstate)
        V_IDLE: begin
          o_shift_clk <= 1'b0;
          if (o_print_request && rdy_s2 && fifo_out_valid)
            vstate <= V_LOAD;
        end
        V_LOAD: begin
          // Stalls here if the processor reload falls behind the engine
          if (fifo_out_valid) begin
            shreg  <= fifo_out_data;
            bitn   <= 3'h0;
            div    <= 4'h0;
            vstate <= V_SHIFT;
          end
        end
        V_SHIFT: begin
          div <= div + 4'h1;
          if (div == 4'h0) begin
            o_video_data <= shreg[7];
            o_shift_clk  <= 1'b0;
          end else if (div == `PFVS_SHIFT_DIV - 4'h1) begin
            o_shift_clk <= 1'b1;
          end else if (div == `PFVS_SHIFT_DIV + `PFVS_SHIFT_DIV - 4'h1) begin
            o_shift_clk <= 1'b0;
            div         <= 4'h0;
            shreg       <= {shreg[6:0], 1'b0};
            bitn        <= bitn + 3'h1;
            if (bitn == 3'h7) begin
              if (vcount == LINE_BYTES[8:0] - 9'h001) begin
                vcount      <= 9'h000;
                o_line_sent <= 1'b1;
                vstate      <= V_IDLE;
              end else begin
                vcount <= vcount + 9'h001;
                vstate <= V_LOAD;
              end
            end
          end
        end
        default: vstate <= V_IDLE;
      endcase
    end
  end
endmodule // pfvs_top
`default_nettype wire

// ===== sim/pfvs_top_assertions.sv
// Concurrent checks on the page FIFO and video serializer ports
`default_nettype none
module pfvs_checker (
  // Clock and reset
  input wire logic       i_clk,
  input wire logic       i_rst,
  // Mover, raster and line ports
  input wire logic       i_cnt_load,
  input wire logic [9:0] i_cnt_value,
  input wire logic       o_mover_busy,
  input wire logic       o_cnt_error,
  input wire logic       i_host_valid,
  input wire logic       o_host_ready,
  input wire logic       o_fb_wr,
  input wire logic       i_fb_rvalid,
  input wire logic       i_line_valid,
  input wire logic       o_line_ready,
  input wire logic       o_line_request,
  input wire logic       i_page_done,
  // Engine link
  input wire logic       i_engine_ready,
  input wire logic       o_print_request,
  input wire logic       o_video_data,
  input wire logic       o_shift_clk,
  input wire logic       o_line_sent
);
  timeunit 1ns;
  timeprecision 1ns;
  logic        page_seen;
  logic [8:0]  line_cnt;
  logic [11:0] bit_cnt;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  ////////////////////////////////////////
  // Page seen, line bytes taken, shift clocks per line; line count saturates so it never wraps
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      page_seen <= 1'b0;
      line_cnt  <= 9'h000;
      bit_cnt   <= 12'h000;
    end else begin
      page_seen <= page_seen | i_page_done;
      if (i_line_valid && o_line_ready && line_cnt != 9'h1ff) begin
        line_cnt <= line_cnt + 9'h001;
      end
      if (o_line_sent) begin
        bit_cnt <= 12'h000;
      end else if ($rose(o_shift_clk)) begin
        bit_cnt <= bit_cnt + 12'h001;
      end
    end
  end
  ////////////////////////////////////////
  a_load_starts:
    assert property (i_cnt_load && !o_mover_busy && !o_print_request && i_cnt_value != 10'h000
      && i_cnt_value <= 10'h200 |=> o_mover_busy) else $error("mover did not start");
  a_bad_count:
    assert property (i_cnt_load && !o_mover_busy && !o_print_request && (i_cnt_value == 10'h000
      || i_cnt_value > 10'h200) |=> o_cnt_error) else $error("bad count not flagged");
  a_ready_busy:
    assert property (o_host_ready |-> o_mover_busy) else $error("host ready while mover idle");
  a_byte_gap:
    assert property (i_host_valid && o_host_ready |=> !o_host_ready [*8]) else $error("bytes too close");
  a_wr_after_rd:
    assert property (o_fb_wr |-> $past(i_fb_rvalid)) else $error("write without read answer");
  a_print_late:
    assert property (o_print_request |-> page_seen) else $error("print before page done");
  a_line_first:
    assert property ($rose(o_print_request) |-> line_cnt >= 9'h01f) else $error("print before line loaded");
  a_ready_first:
    assert property (o_shift_clk |-> $past(i_engine_ready, 2)) else $error("shift before engine ready");
  a_clk_width:
    assert property ($rose(o_shift_clk) |=> o_shift_clk ##1 !o_shift_clk) else $error("shift clock width");
  a_data_steady:
    assert property (o_shift_clk |-> $stable(o_video_data)) else $error("dot moved under shift clock");
  a_line_bits:
    assert property (o_line_sent |-> bit_cnt == 12'h960) else $error("wrong bit count in line");
  a_next_line:
    assert property (o_line_sent && !i_page_done |-> ##[0:8] o_line_request) else $error("no refill");
endmodule // pfvs_checker
bind pfvs_top pfvs_checker i_chk (
  .i_clk, .i_rst, .i_cnt_load, .i_cnt_value, .o_mover_busy, .o_cnt_error, .i_host_valid, .o_host_ready,
  .o_fb_wr, .i_fb_rvalid, .i_line_valid, .o_line_ready, .o_line_request, .i_page_done, .i_engine_ready,
  .o_print_request, .o_video_data, .o_shift_clk, .o_line_sent
);
`default_nettype wire

// ===== sim/pfvs_partner.sv
// Far side model: frame memory, scan line feeder and print engine
`default_nettype none
module pfvs_partner (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  // Frame buffer port
  input  wire logic        i_fb_rd,
  input  wire logic        i_fb_wr,
  input  wire logic [19:0] i_fb_addr,
  input  wire logic [7:0]  i_fb_wdata,
  output logic      [7:0]  o_fb_rdata,
  output logic             o_fb_rvalid,
  // Scan line feed
  input  wire logic        i_line_request,
  input  wire logic        i_line_ready,
  output logic             o_line_valid,
  output logic      [7:0]  o_line_data,
  // Engine link
  input  wire logic        i_print_request,
  input  wire logic        i_shift_clk,
  input  wire logic        i_video_data,
  output logic             o_engine_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [0:2047];
  logic [7:0] rx [0:299];
  int         rx_n;
  logic [8:0] lcnt;
  logic [4:0] wait_cnt;
  logic [7:0] sh;
  logic [2:0] nbit;
  logic       sclk_q;
  // Frame memory starts from a known background
  initial begin
    for (int i = 0; i < 2048; i++) begin
      mem[i] = 8'h3c;
    end
  end
  ////////////////////////////////////////
  // Read data toggles when idle so a stale byte is never mistaken for an answer
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_fb_rvalid <= 1'b0;
      o_fb_rdata <= 8'h00;
      o_line_valid <= 1'b0;
      o_line_data <= 8'h00;
      lcnt <= 9'h000;
      wait_cnt <= 5'h00;
      o_engine_ready <= 1'b0;
      sclk_q <= 1'b0;
      sh <= 8'h00;
      nbit <= 3'h0;
      rx_n <= 0;
    end else begin
      o_fb_rvalid <= i_fb_rd;
      o_fb_rdata <= i_fb_rd ? mem[i_fb_addr[10:0]] : ~o_fb_rdata;
      if (i_fb_wr) begin
        mem[i_fb_addr[10:0]] <= i_fb_wdata;
      end
      // Line bytes follow a counting pattern, 300 per request
      if (i_line_request) begin
        o_line_valid <= 1'b1;
        lcnt <= 9'h000;
        o_line_data <= 8'h5a;
      end else if (o_line_valid && i_line_ready) begin
        lcnt <= lcnt + 9'h001;
        o_line_valid <= (lcnt != 9'h12b);
        o_line_data <= (lcnt == 9'h12b) ? ~o_line_data : ((lcnt[7:0] + 8'h01) ^ 8'h5a);
      end
      // Engine answers the print request after a warm-up delay
      if (i_print_request && wait_cnt != 5'h14) begin
        wait_cnt <= wait_cnt + 5'h01;
      end
      o_engine_ready <= (wait_cnt == 5'h14);
      // Dots are taken on the shift clock rising edge, first bit is the byte's top bit
      sclk_q <= i_shift_clk;
      if (i_shift_clk && !sclk_q) begin
        sh <= {sh[6:0], i_video_data};
        nbit <= nbit + 3'h1;
        if (nbit == 3'h7 && rx_n < 300) begin
          rx[rx_n] <= {sh[6:0], i_video_data};
          rx_n <= rx_n + 1;
        end
      end
    end
  end
endmodule // pfvs_partner
`default_nettype wire

// ===== sim/test_page_fifo_video_serializer.sv
// Self-checking bench for the page FIFO and video serializer
`default_nettype none
module test_page_fifo_video_serializer;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clk = 1'b0, i_rst = 1'b1, i_cnt_load = 1'b0, i_host_valid = 1'b0, i_rop_start = 1'b0, i_page_done = 1'b0;
  logic [9:0] i_cnt_value = 10'h000;
  logic [7:0] i_host_data = 8'h00;
  logic [19:0] i_rop_addr = 20'h00000;
  logic [1:0] i_rop_op = 2'h0;
  logic [7:0] i_fb_rdata, i_line_data, o_fb_wdata;
  logic i_fb_rvalid, i_line_valid, i_engine_ready, o_mover_busy, o_cnt_error, o_host_ready, o_rop_busy, o_fb_rd;
  logic o_fb_wr, o_line_ready, o_line_request, o_print_request, o_video_data, o_shift_clk, o_line_sent;
  logic [19:0] o_fb_addr;
  logic [8:0] o_line_index;
  int err_count = 0;
  int checked = 0;
  pfvs_top i_dut (
    .i_clk, .i_rst, .i_cnt_load, .i_cnt_value, .o_mover_busy, .o_cnt_error, .i_host_valid, .o_host_ready,
    .i_host_data, .i_rop_start, .i_rop_addr, .i_rop_op, .i_page_done, .o_rop_busy, .o_fb_rd, .o_fb_wr,
    .o_fb_addr, .o_fb_wdata, .i_fb_rdata, .i_fb_rvalid, .i_line_valid, .o_line_ready, .i_line_data,
    .o_line_request, .o_line_index, .i_engine_ready, .o_print_request, .o_video_data, .o_shift_clk, .o_line_sent
  );
  pfvs_partner i_partner (
    .i_clk, .i_rst, .i_fb_rd(o_fb_rd), .i_fb_wr(o_fb_wr), .i_fb_addr(o_fb_addr), .i_fb_wdata(o_fb_wdata),
    .o_fb_rdata(i_fb_rdata), .o_fb_rvalid(i_fb_rvalid), .i_line_request(o_line_request),
    .i_line_ready(o_line_ready), .o_line_valid(i_line_valid), .o_line_data(i_line_data),
    .i_print_request(o_print_request), .i_shift_clk(o_shift_clk), .i_video_data(o_video_data),
    .o_engine_ready(i_engine_ready)
  );
  ////////////////////////////////////////
  // Clock at 10 MHz
  always #50 i_clk = ~i_clk;
  // Compare one value and count it
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Bounded wait for a level, sampled clear of the edge
  task automatic wait_for(ref logic s, input logic v, input int lim);
    int k;
    k = 0;
    do begin
      @(posedge i_clk);
      #1;
      k++;
    end while (s !== v && k < lim);
    chk(s, v);
  endtask
  task automatic print_verdict;
    $display("checked=%0d err_count=%0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  // Zero and one-past-maximum counts are refused
  task automatic t_counts(input logic [9:0] v);
    @(posedge i_clk);
    i_cnt_load <= 1'b1;
    i_cnt_value <= v;
    @(posedge i_clk);
    i_cnt_load <= 1'b0;
    #1;
    chk(o_cnt_error, 1'b1);
    chk(o_mover_busy, 1'b0);
  endtask
  // Counted transfer through the FIFO into frame memory with one combine operation
  task automatic t_rop(input logic [1:0] op, input int n);
    logic [7:0] d;
    logic [7:0] e;
    @(posedge i_clk);
    i_rop_start <= 1'b1;
    i_rop_addr <= {9'h000, op, 9'h000};
    i_rop_op <= op;
    i_cnt_load <= 1'b1;
    i_cnt_value <= n[9:0];
    i_host_valid <= 1'b1;
    i_host_data <= 8'ha5;
    for (int i = 0; i < n; i++) begin
      wait_for(o_host_ready, 1'b1, 40);
      @(posedge i_clk);
      i_rop_start <= 1'b0;
      i_cnt_load <= 1'b0;
      i_host_data <= (i[7:0] + 8'h01) ^ 8'ha5;
    end
    // A byte beyond the count must stay untaken
    repeat (40) begin
      @(posedge i_clk);
      #1;
      chk(o_host_ready, 1'b0);
    end
    i_host_valid <= 1'b0;
    i_host_data <= ~i_host_data;
    wait_for(o_rop_busy, 1'b0, 200);
    chk(o_print_request, 1'b0);
    for (int i = 0; i < n; i++) begin
      d = i[7:0] ^ 8'ha5;
      e = (op == 2'h0) ? (8'h3c | d) : (op == 2'h1) ? (8'h3c ^ d) : (op == 2'h2) ? d : (8'h3c & ~d);
      chk(i_partner.mem[{op, i[8:0]}], e);
    end
  endtask
  // Page done, first line reloaded, serialized after engine ready, then refill
  task automatic t_print;
    @(posedge i_clk);
    i_page_done <= 1'b1;
    @(posedge i_clk);
    i_page_done <= 1'b0;
    // The request pulse stands for this one cycle only
    #1;
    chk(o_line_request, 1'b1);
    chk(o_line_index, 9'h000);
    wait_for(o_line_sent, 1'b1, 15000);
    chk(o_print_request, 1'b1);
    chk(i_partner.rx_n, 300);
    for (int i = 0; i < 300; i++) begin
      chk(i_partner.rx[i], i[7:0] ^ 8'h5a);
    end
    wait_for(o_line_request, 1'b1, 20);
    chk(o_line_index, 9'h001);
  endtask
  ////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (3) @(posedge i_clk);
    i_rst <= 1'b0;
    t_counts(10'h000);
    for (int k = 0; k < 4; k++) begin
      t_rop(k[1:0], (k == 2) ? 512 : 4);
      // The good load cleared the error, so this refusal is seen afresh
      if (k == 0) begin
        t_counts(10'h201);
      end
    end
    t_print;
    print_verdict;
  end
  // Watchdog well beyond the expected 19000 cycles
  initial begin
    #4000000;
    err_count++;
    print_verdict;
  end
endmodule // test_page_fifo_video_serializer
`default_nettype wire
